// ---- bench/flash_self_program_sequencer_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "fsp_defines.svh"
module flash_self_program_sequencer_test;
    import fsp_pkg::*;
    localparam int PROG = 20;
    localparam logic [7:0] LOW_P = 8'h5a;
    localparam logic [7:0] HIGH_P = 8'h81;
    localparam logic [7:0] LOCK_P = 8'h02;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ee_start = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, ee_busy, halt;
    logic [7:0] cfg_lo, cfg_hi, lock;
    logic [31:0] r;
    logic e;
    int fail_count = 0;
    int check_count = 0;
    int halt_cnt = 0;
    int n;
    logic [31:0] bad[4] = '{32'h07, 32'h1f, 32'h0b, 32'h02};

    // =====
    // clock, halt watch, instances
    always #10 clk = ~clk;
    // halt is counted edge by edge so its length is exact
    always @(posedge clk)
        if (halt === 1'b1)
            halt_cnt++;
    fsp_sequencer #(.PROG_CYCLES(PROG)) dut (.ref_clk_i(clk), .rst_b_i(rst_b),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .eeprom_write_busy_i(ee_busy), .config_low_prog_i(cfg_lo),
        .config_high_prog_i(cfg_hi), .lock_prog_i(lock), .cpu_halt_o(halt));
    fsp_pin_model #(.LOW_PROG(LOW_P), .HIGH_PROG(HIGH_P), .LOCK_PROG(LOCK_P)) pins (
        .ref_clk_i(clk), .rst_b_i(rst_b), .ee_start_i(ee_start),
        .eeprom_write_busy_o(ee_busy), .config_low_prog_o(cfg_lo),
        .config_high_prog_o(cfg_hi), .lock_prog_o(lock));

    // =====
    // bus tasks
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    // one idle cycle after each transfer keeps drivers single per step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 400);
        if (k >= 400)
        begin
            $display("BAD pready expected 1 seen %b", pready);
            fail_count++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, d, x, y);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] x;
        logic y;
        apb(1'b0, a, 32'h0, x, y);
        chk(what, exp, x);
    endtask

    // =====
    // sequencer operations
    function automatic logic [31:0] zp(input int p, input int w, input int b);
        return 32'((p << 6) | (w << 1) | b);
    endfunction
    task automatic prog(input logic [4:0] cmd, input logic [31:0] z);
        halt_cnt = 0;
        wr(`FSP_OFF_ZPTR, z);
        wr(`FSP_OFF_CTRL, {27'h0, cmd});
        wr(`FSP_OFF_OPCMD, 32'h1);
        rdc(`FSP_OFF_STATUS, 32'h0, "status after program");
        chk("halt cycles", 32'(PROG), 32'(halt_cnt));
    endtask
    // erase with junk word bits, write with them zero
    task automatic pg(input int p);
        prog(`FSP_CMD_ERASE, zp(p, 31, 1));
        prog(`FSP_CMD_WRITE, zp(p, 0, 0));
    endtask
    task automatic ld(input int p, input int w, input logic [15:0] d);
        wr(`FSP_OFF_ZPTR, zp(p, w, 0));
        wr(`FSP_OFF_DATA, {16'h0, d});
        wr(`FSP_OFF_CTRL, {27'h0, `FSP_CMD_LOAD});
        wr(`FSP_OFF_OPCMD, 32'h1);
    endtask
    task automatic fetch(input logic [31:0] z, input logic [7:0] exp, input string what);
        wr(`FSP_OFF_ZPTR, z);
        wr(`FSP_OFF_OPCMD, 32'h2);
        rdc(`FSP_OFF_RESULT, {24'h0, exp}, what);
    endtask
    task automatic cfg(input logic [31:0] z, input logic [7:0] exp, input string what);
        wr(`FSP_OFF_ZPTR, z);
        wr(`FSP_OFF_CTRL, {27'h0, `FSP_CMD_READ_CONFIG_BITS_BIT});
        wr(`FSP_OFF_OPCMD, 32'h2);
        rdc(`FSP_OFF_RESULT, {24'h0, exp}, what);
    endtask

    // =====
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdc(`FSP_OFF_CTRL, 32'h0, "ctrl reset");
        rdc(`FSP_OFF_STATUS, 32'h0, "status reset");
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        cfg(32'h0000, ~LOW_P, "low fuse");
        cfg(32'h0001, ~LOCK_P, "lock byte");
        cfg(32'h0003, ~HIGH_P, "high fuse");
        // page 3: out of order loads before the erase
        ld(3, 5, 16'h1234);
        ld(3, 2, 16'h00c3);
        pg(3);
        fetch(zp(3, 5, 0), 8'h34, "word 5 low");
        fetch(zp(3, 5, 1), 8'h12, "word 5 high");
        fetch(zp(3, 2, 0), 8'hc3, "word 2 low");
        fetch(zp(3, 7, 1), 8'hff, "unloaded word");
        // expired read-config window falls back to a flash byte
        wr(`FSP_OFF_ZPTR, zp(3, 5, 0));
        wr(`FSP_OFF_CTRL, {27'h0, `FSP_CMD_READ_CONFIG_BITS_BIT});
        // one spare cycle puts the load on the fourth edge, just past the window
        @(posedge clk);
        wr(`FSP_OFF_OPCMD, 32'h2);
        rdc(`FSP_OFF_CTRL, 32'h0, "ctrl after config expiry");
        rdc(`FSP_OFF_RESULT, 32'h34, "load after expiry");
        // page 4: clear command, then clear on write done
        ld(4, 2, 16'h0000);
        wr(`FSP_OFF_CTRL, {27'h0, `FSP_CMD_CLEAR});
        pg(4);
        fetch(zp(4, 2, 0), 8'hff, "word after clear");
        fetch(zp(4, 5, 0), 8'hff, "word after write done");
        // page 7: refused codes and unarmed store
        wr(`FSP_OFF_ZPTR, zp(7, 3, 0));
        wr(`FSP_OFF_DATA, 32'h0);
        foreach (bad[i])
        begin
            wr(`FSP_OFF_CTRL, bad[i]);
            rdc(`FSP_OFF_CTRL, 32'h0, "ctrl after bad code");
        end
        wr(`FSP_OFF_CTRL, {27'h0, `FSP_CMD_LOAD});
        // store lands on the fifth edge after arming, one past the window
        repeat (2) @(posedge clk);
        halt_cnt = 0;
        wr(`FSP_OFF_OPCMD, 32'h1);
        rdc(`FSP_OFF_CTRL, 32'h0, "ctrl after store expiry");
        chk("halt on unarmed store", 32'h0, 32'(halt_cnt));
        pg(7);
        fetch(zp(7, 3, 0), 8'hff, "unarmed store");
        // page 6: eeprom write wipes a part-loaded buffer
        ld(6, 1, 16'h0000);
        ee_start <= 1'b1;
        @(posedge clk);
        ee_start <= 1'b0;
        repeat (4) @(posedge clk);
        wr(`FSP_OFF_CTRL, {27'h0, `FSP_CMD_READ_CONFIG_BITS_BIT});
        rdc(`FSP_OFF_CTRL, 32'h0, "ctrl during eeprom write");
        // a buffer load tried while busy must leave no trace
        wr(`FSP_OFF_ZPTR, zp(6, 4, 0));
        wr(`FSP_OFF_CTRL, {27'h0, `FSP_CMD_LOAD});
        wr(`FSP_OFF_OPCMD, 32'h1);
        n = 0;
        do
        begin
            apb(1'b0, `FSP_OFF_STATUS, 32'h0, r, e);
            n++;
        end
        while (r[1] !== 1'b0 && n < 100);
        chk("eeprom idle", 32'h0, {31'h0, r[1]});
        if (r[1] !== 1'b0)
            stop_test();
        pg(6);
        fetch(zp(6, 1, 0), 8'hff, "word after eeprom write");
        fetch(zp(6, 4, 0), 8'hff, "store during eeprom write");
        // page 5: reset in mid-run empties the buffer
        ld(5, 1, 16'h0000);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        pg(5);
        fetch(zp(5, 1, 0), 8'hff, "word after reset");
        stop_test();
    end
endmodule
`default_nettype wire

// ---- bench/fsp_pin_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// =====
// far side pins: eeprom write engine and fuse cells
module fsp_pin_model #(
    parameter int EE_CYCLES = 40,
    parameter logic [7:0] LOW_PROG = 8'h5a,
    parameter logic [7:0] HIGH_PROG = 8'h81,
    parameter logic [7:0] LOCK_PROG = 8'h02
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // eeprom write request from the bench
    input wire logic ee_start_i,
    // pins seen by the sequencer, 1 = programmed
    output logic eeprom_write_busy_o,
    output logic [7:0] config_low_prog_o,
    output logic [7:0] config_high_prog_o,
    output logic [7:0] lock_prog_o
);
    int ee_cnt_ff;
    // busy lasts a fixed time, long enough to outlast the sync delay
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            ee_cnt_ff <= 0;
        else if (ee_start_i)
            ee_cnt_ff <= EE_CYCLES;
        else if (ee_cnt_ff != 0)
            ee_cnt_ff <= ee_cnt_ff - 1;
    end
    // fuse cells never change at run time
    assign eeprom_write_busy_o = (ee_cnt_ff != 0);
    assign config_low_prog_o = LOW_PROG;
    assign config_high_prog_o = HIGH_PROG;
    assign lock_prog_o = LOCK_PROG;
endmodule
`default_nettype wire

// ---- logic/fsp_defines.svh ----
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// ==========================================
// register offsets (byte addresses on the bus)
`define FSP_OFF_CTRL 8'h00
`define FSP_OFF_ZPTR 8'h04
`define FSP_OFF_DATA 8'h08
`define FSP_OFF_OPCMD 8'h0c
`define FSP_OFF_RESULT 8'h10
`define FSP_OFF_STATUS 8'h14

// ==========================================
// control register commands, lower five bits
`define FSP_CMD_LOAD 5'b00001
`define FSP_CMD_ERASE 5'b00011
`define FSP_CMD_WRITE 5'b00101
`define FSP_CMD_READ_CONFIG_BITS_BIT 5'b01001
`define FSP_CMD_CLEAR 5'b10001

// ==========================================
// operation register bits
`define FSP_OP_STORE 0
`define FSP_OP_LOAD 1

// ==========================================
// armed windows in clock cycles
`define FSP_STORE_WIN 3'd4
`define FSP_LOAD_WIN 3'd3

// ==========================================
// address pointer layout and geometry
`define FSP_PAGE_WORDS 32
`define FSP_FLASH_WORDS 2048
`define FSP_PAGE_HI 11
`define FSP_PAGE_LO 6
`define FSP_WORD_HI 5
`define FSP_WORD_LO 1
`define FSP_Z_FUSE_LOW 16'h0000
`define FSP_Z_LOCK 16'h0001
`define FSP_Z_FUSE_HIGH 16'h0003
`define FSP_ERASED_WORD 16'hffff

// ==========================================
// timing: 3.7 ms least programming time
`define FSP_PROG_MIN_US 3700
`define FSP_CLK_PERIOD_NS 20

`endif

// ---- logic/fsp_page_buffer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "fsp_defines.svh"

module fsp_page_buffer
    import fsp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // control
    input wire logic clr_i,
    input wire logic wr_en_i,
    input wire logic [4:0] wr_idx_i,
    input wire logic [15:0] wr_data_i,
    // contents
    output logic [`FSP_PAGE_WORDS-1:0][15:0] words_o
);

    // ==========================================
    // one word per entry, any order of loads
    genvar g;
    generate
        for (g = 0; g < `FSP_PAGE_WORDS; g++)
        begin : g_word
            logic [15:0] word_ff;
            // reset and clear return the word to the erased pattern
            always_ff @(posedge ref_clk_i)
            begin
                if (!rst_b_i || clr_i)
                    word_ff <= `FSP_ERASED_WORD;
                else if (wr_en_i && wr_idx_i == 5'(g))
                    word_ff <= wr_data_i;
            end
            assign words_o[g] = word_ff;
        end
    endgenerate

    // ==========================================
    // checks
    a_buffer_clear_all: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        clr_i |=> (&words_o))
        else $error("page buffer not cleared");

endmodule
`default_nettype wire

// ---- logic/fsp_pkg.sv ----
`default_nettype none
package fsp_pkg;

    // armed command kinds
    typedef enum logic [2:0] {
        FSP_MODE_LOAD,
        FSP_MODE_ERASE,
        FSP_MODE_WRITE,
        FSP_MODE_READ_CONFIG_BITS_BIT,
        FSP_MODE_CLEAR
    } fsp_mode_type;

    // sequencer states
    typedef enum logic [1:0] {
        FSP_ST_IDLE,
        FSP_ST_ARMED,
        FSP_ST_BUSY
    } fsp_state_type;

endpackage
`default_nettype wire

// ---- logic/fsp_sequencer.sv ----
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "fsp_defines.svh"

// Function
// - control 00000011 then store op within four cycles erases page from page_index_field
// - control 00000001 then store op loads data pair into buffer at word_in_page_field
// - control 00000101 then store op writes buffer into selected page
// - cpu stays halted for the whole page erase
// - cpu stays halted for the whole page write
// - buffer clears on page write done, clear_buffer_bit and reset
// - eeprom write starting discards partly loaded buffer words
// - eeprom write in progress blocks programming and config reads
// - pointer 0x0001, read-config armed, load within three cycles returns lock byte
// - read-config and store enable self-clear on completion or window expiry
// - pointer 0x0000 with read-config armed returns config_low_byte
// - pointer 0x0003 with read-config armed returns config_high_byte
// - programmed bits read as zero, unprogrammed bits read as one
// - ordinary load reads a byte, pointer bit 0 picks low or high
// - erase ignores pointer bits outside page_index_field
// - low pointer bits pick word, high bits pick page
// - buffer accepts word loads in any order
// - control bits 4..0 clear, read-config, write, erase, enable; 7..5 zero
// - control writes with other lower five bits have no effect
// - store enable arms four cycles, three with read-config, stays set while erase or write runs
// - each erase or write lasts at least 3.7 ms
module fsp_sequencer
    import fsp_pkg::*;
#(
    parameter int PROG_CYCLES =
        (`FSP_PROG_MIN_US * 1000 + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // eeprom and configuration pins, 1 = programmed
    input wire logic eeprom_write_busy_i,
    input wire logic [7:0] config_low_prog_i,
    input wire logic [7:0] config_high_prog_i,
    input wire logic [7:0] lock_prog_i,
    // cpu stall
    output logic cpu_halt_o
);

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    // ==========================================
    // pin synchronisers
    logic eep_s1_ff;
    logic eep_s2_ff;
    logic eep_d_ff;
    logic [23:0] cfg_s1_ff;
    logic [23:0] cfg_s2_ff;

    // two stages, plus a delay flop on eeprom busy for its rising edge; the first stage is never looked at
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            eep_s1_ff <= 1'b0;
            eep_s2_ff <= 1'b0;
            eep_d_ff <= 1'b0;
            cfg_s1_ff <= 24'h000000;
            cfg_s2_ff <= 24'h000000;
        end
        else
        begin
            eep_s1_ff <= eeprom_write_busy_i;
            eep_s2_ff <= eep_s1_ff;
            eep_d_ff <= eep_s2_ff;
            cfg_s1_ff <= {config_high_prog_i, config_low_prog_i, lock_prog_i};
            cfg_s2_ff <= cfg_s1_ff;
        end
    end

    // ==========================================
    // state
    fsp_state_type state_ff;
    fsp_mode_type mode_ff;
    logic [2:0] win_cnt_ff;
    logic [CNT_W-1:0] prog_cnt_ff;
    logic [5:0] page_ff;
    logic halt_ff;
    logic [15:0] zptr_ff;
    logic [15:0] data_ff;
    logic [7:0] result_ff;
    logic pready_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic [15:0] flash_mem [0:`FSP_FLASH_WORDS-1];
    logic [`FSP_PAGE_WORDS-1:0][15:0] buf_words;

    // ==========================================
    // bus decode; a write takes effect only at the completing edge
    logic acc_wr;
    logic ctrl_wr;
    logic store_op;
    logic load_op;
    assign acc_wr = psel_i & penable_i & pready_ff & pwrite_i;
    assign ctrl_wr = acc_wr && (paddr_i == `FSP_OFF_CTRL);
    assign store_op = acc_wr && (paddr_i == `FSP_OFF_OPCMD) && pwdata_i[`FSP_OP_STORE];
    assign load_op = acc_wr && (paddr_i == `FSP_OFF_OPCMD) && pwdata_i[`FSP_OP_LOAD];

    // command decode of the lower five control bits
    logic req_legal;
    fsp_mode_type req_mode;
    always_comb
    begin
        req_legal = 1'b1;
        req_mode = FSP_MODE_LOAD;
        case (pwdata_i[4:0])
            `FSP_CMD_LOAD: req_mode = FSP_MODE_LOAD;
            `FSP_CMD_ERASE: req_mode = FSP_MODE_ERASE;
            `FSP_CMD_WRITE: req_mode = FSP_MODE_WRITE;
            `FSP_CMD_READ_CONFIG_BITS_BIT: req_mode = FSP_MODE_READ_CONFIG_BITS_BIT;
            `FSP_CMD_CLEAR: req_mode = FSP_MODE_CLEAR;
            default: req_legal = 1'b0;
        endcase
    end

    // ==========================================
    // arming and hits
    logic arm;
    logic store_hit;
    logic cfg_hit;
    logic done;
    logic buf_clr;
    logic [2:0] win_lim;
    // eeprom busy refuses the control write outright
    assign arm = ctrl_wr && req_legal && !eep_s2_ff && (state_ff != FSP_ST_BUSY);
    assign win_lim = (mode_ff == FSP_MODE_READ_CONFIG_BITS_BIT) ? `FSP_LOAD_WIN : `FSP_STORE_WIN;
    assign store_hit = store_op && (state_ff == FSP_ST_ARMED) && !eep_s2_ff;
    assign cfg_hit = load_op && (state_ff == FSP_ST_ARMED) && (mode_ff == FSP_MODE_READ_CONFIG_BITS_BIT)
        && !eep_s2_ff;
    assign done = (state_ff == FSP_ST_BUSY) && (prog_cnt_ff == '0);
    // write done, clear command, or eeprom write starting
    assign buf_clr = (arm && req_mode == FSP_MODE_CLEAR)
        || (done && mode_ff == FSP_MODE_WRITE)
        || (eep_s2_ff && !eep_d_ff);

    // ==========================================
    // sequencer
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            state_ff <= FSP_ST_IDLE;
            mode_ff <= FSP_MODE_LOAD;
            win_cnt_ff <= 3'd0;
            prog_cnt_ff <= '0;
            page_ff <= 6'h00;
            halt_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                FSP_ST_IDLE:
                begin
                    if (arm)
                    begin
                        state_ff <= FSP_ST_ARMED;
                        mode_ff <= req_mode;
                        win_cnt_ff <= 3'd0;
                    end
                end
                FSP_ST_ARMED:
                begin
                    if (eep_s2_ff)
                        state_ff <= FSP_ST_IDLE;
                    else if (store_hit)
                    begin
                        if (mode_ff == FSP_MODE_ERASE || mode_ff == FSP_MODE_WRITE)
                        begin
                            state_ff <= FSP_ST_BUSY;
                            halt_ff <= 1'b1;
                            prog_cnt_ff <= CNT_W'(PROG_CYCLES - 1);
                            page_ff <= zptr_ff[`FSP_PAGE_HI:`FSP_PAGE_LO];
                        end
                        else
                            state_ff <= FSP_ST_IDLE;
                    end
                    else if (cfg_hit)
                        state_ff <= FSP_ST_IDLE;
                    else if (arm)
                    begin
                        mode_ff <= req_mode;
                        win_cnt_ff <= 3'd0;
                    end
                    else if (win_cnt_ff == win_lim - 3'd1)
                        state_ff <= FSP_ST_IDLE;
                    else
                        win_cnt_ff <= win_cnt_ff + 3'd1;
                end
                FSP_ST_BUSY:
                begin
                    // enable stays readable as set until the page is done
                    if (done)
                    begin
                        state_ff <= FSP_ST_IDLE;
                        halt_ff <= 1'b0;
                    end
                    else
                        prog_cnt_ff <= prog_cnt_ff - CNT_W'(1);
                end
                default:
                begin
                    state_ff <= FSP_ST_IDLE;
                    halt_ff <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // page buffer
    fsp_page_buffer u_buf (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clr_i(buf_clr),
        .wr_en_i(store_hit && mode_ff == FSP_MODE_LOAD),
        .wr_idx_i(zptr_ff[`FSP_WORD_HI:`FSP_WORD_LO]),
        .wr_data_i(data_ff),
        .words_o(buf_words)
    );

    // ==========================================
    // flash array; programming can only clear bits, so a write ands
    // the buffer into the erased page
    always_ff @(posedge ref_clk_i)
    begin
        if (done)
        begin
            for (int i = 0; i < `FSP_PAGE_WORDS; i++)
            begin
                if (mode_ff == FSP_MODE_ERASE)
                    flash_mem[{page_ff, 5'(i)}] <= `FSP_ERASED_WORD;
                else
                    flash_mem[{page_ff, 5'(i)}] <= flash_mem[{page_ff, 5'(i)}]
                        & buf_words[i];
            end
        end
    end

    // ==========================================
    // load results
    logic [7:0] flash_byte;
    logic [7:0] cfg_byte;
    logic [15:0] flash_word;
    assign flash_word = flash_mem[zptr_ff[`FSP_PAGE_HI:1]];
    assign flash_byte = zptr_ff[0] ? flash_word[15:8] : flash_word[7:0];

    // stored masks mark programmed bits, so invert on the way out
    always_comb
    begin
        case (zptr_ff)
            `FSP_Z_LOCK: cfg_byte = ~cfg_s2_ff[7:0];
            `FSP_Z_FUSE_LOW: cfg_byte = ~cfg_s2_ff[15:8];
            `FSP_Z_FUSE_HIGH: cfg_byte = ~cfg_s2_ff[23:16];
            default: cfg_byte = 8'hff;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            result_ff <= 8'h00;
        else if (cfg_hit)
            result_ff <= cfg_byte;
        else if (load_op)
            result_ff <= flash_byte;
    end

    // pointer and data pair registers
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            zptr_ff <= 16'h0000;
            data_ff <= 16'h0000;
        end
        else
        begin
            if (acc_wr && paddr_i == `FSP_OFF_ZPTR)
                zptr_ff <= pwdata_i[15:0];
            if (acc_wr && paddr_i == `FSP_OFF_DATA)
                data_ff <= pwdata_i[15:0];
        end
    end

    // ==========================================
    // apb read mux
    logic [31:0] rd_val;
    logic mapped;
    logic armed;
    logic [4:0] ctrl_val;
    assign armed = (state_ff != FSP_ST_IDLE);
    // clear bit always reads zero, it acts at once
    assign ctrl_val = {1'b0, armed && mode_ff == FSP_MODE_READ_CONFIG_BITS_BIT,
        armed && mode_ff == FSP_MODE_WRITE,
        armed && mode_ff == FSP_MODE_ERASE, armed};
    always_comb
    begin
        mapped = 1'b1;
        rd_val = 32'h00000000;
        case (paddr_i)
            `FSP_OFF_CTRL: rd_val = {27'h0000000, ctrl_val};
            `FSP_OFF_ZPTR: rd_val = {16'h0000, zptr_ff};
            `FSP_OFF_DATA: rd_val = {16'h0000, data_ff};
            `FSP_OFF_OPCMD: rd_val = 32'h00000000;
            `FSP_OFF_RESULT: rd_val = {24'h000000, result_ff};
            `FSP_OFF_STATUS: rd_val = {29'h00000000, armed, eep_s2_ff, halt_ff};
            default: mapped = 1'b0;
        endcase
    end

    // one wait-free access phase; a running erase or write holds
    // pready low, which is how the cpu is stalled on the bus
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= psel_i && !pready_ff && (state_ff != FSP_ST_BUSY);
            if (psel_i && !pready_ff)
            begin
                prdata_ff <= rd_val;
                pslverr_ff <= !mapped;
            end
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign cpu_halt_o = halt_ff;

    // ==========================================
    // checks
    int hlen_ff;
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i || !halt_ff)
            hlen_ff <= 0;
        else
            hlen_ff <= hlen_ff + 1;
    end

    a_halt_full_len: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $fell(cpu_halt_o) |-> hlen_ff == PROG_CYCLES)
        else $error("programming time wrong");

    a_halt_while_busy: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (state_ff == FSP_ST_BUSY) |-> cpu_halt_o && !pready_o)
        else $error("cpu not halted during programming");

    a_bad_ctrl_ignored: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (ctrl_wr && !req_legal && state_ff == FSP_ST_IDLE) |=> state_ff == FSP_ST_IDLE)
        else $error("illegal control write took effect");

    a_window_bound: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (state_ff == FSP_ST_ARMED) |-> win_cnt_ff < win_lim)
        else $error("armed window too long");

    a_eep_blocks_arm: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (eep_s2_ff && state_ff != FSP_ST_BUSY) |=> state_ff == FSP_ST_IDLE)
        else $error("armed during eeprom write");

    a_lock_read_value: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (cfg_hit && zptr_ff == `FSP_Z_LOCK) |=> result_ff == ~$past(cfg_s2_ff[7:0]))
        else $error("lock byte read wrong");

    a_plain_load_byte: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (load_op && state_ff == FSP_ST_IDLE) |=> result_ff == $past(flash_byte))
        else $error("ordinary byte load wrong");

    a_write_clears_buf: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (done && mode_ff == FSP_MODE_WRITE) |=> ##1 (&buf_words))
        else $error("buffer kept after page write");

endmodule
`default_nettype wire
